// [verilog/tws_pkg.sv]
// Constants, register map and types of the two-wire slave receiver
package tws_pkg;
  // Register byte offsets on the Wishbone port
  localparam logic [3:0] OFS_OWN_ADDR = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_DATA = 4'hC;
  // Control register bit positions
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK_EN = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_IF_EN = 2;
  localparam int CTL_IRQ_EN = 0;
  // Own address register fields
  localparam int OSA_GC_EN = 0;
  // Reset values, general call address and bits per byte
  localparam logic [7:0] OSA_RST = 8'hFE;
  localparam logic [7:0] STATUS_RST = 8'hF8;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Status codes, low three bits read as zero
  localparam logic [7:0] SC_OWN_W = 8'h60;
  localparam logic [7:0] SC_ARB_OWN_W = 8'h68;
  localparam logic [7:0] SC_GC = 8'h70;
  localparam logic [7:0] SC_ARB_GC = 8'h78;
  localparam logic [7:0] SC_DATA_ACK = 8'h80;
  localparam logic [7:0] SC_DATA_NACK = 8'h88;
  localparam logic [7:0] SC_GC_ACK = 8'h90;
  localparam logic [7:0] SC_GC_NACK = 8'h98;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_DATA, ST_DACK, ST_HOLD
  } tws_state_t;
endpackage

// [verilog/tws_pin_sync.sv]
// Three-stage pin synchroniser; a change counts once stages two and three agree
module tws_pin_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] pinIn,
  output logic [1:0] pinOut
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] level;
  } tws_sync_t;

  tws_sync_t r;
  tws_sync_t next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = pinIn;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < 2; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.level[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign pinOut = r.level;
endmodule // tws_pin_sync

// [verilog/tws_wb_port.sv]
// Classic Wishbone slave port: one wait state, registered ack and read data
module tws_wb_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] rdWord,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  output logic wrEn
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tws_wb_t;

  tws_wb_t r;
  tws_wb_t next_r;

  always_comb begin
    next_r = r;
    next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      next_r.dat = rdWord;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
  assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && r.ack;
endmodule // tws_wb_port

// [verilog/tws_slave_rx.sv]
// Two-wire slave receiver with Wishbone registers and sleep wake-up
//
// The implementer's own choices: the Wishbone register port and the register offsets.
module tws_slave_rx (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sleepMode,
  input wire logic arbLost,
  output logic wakeRequest,
  output logic slaveTransmitSel,
  output logic startPending
);
  typedef struct packed {
    tws_pkg::tws_state_t state;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic sclPrev;
    logic sdaPrev;
    logic busFree;
    logic isGc;
    logic ackBit;
    logic nackd;
    logic sdaDrv;
    logic wake;
    logic stSel;
    logic flag;
    logic ackEn;
    logic startReq;
    logic stopReq;
    logic wcol;
    logic ifEn;
    logic irqEn;
    logic [7:0] osa;
    logic [7:0] status;
    logic [7:0] dataReg;
  } tws_regs_t;

  tws_regs_t r;
  tws_regs_t next_r;
  logic [1:0] pins;
  logic scl;
  logic sda;
  logic wrEn;
  logic lowLane;
  logic [31:0] rdWord;
  logic [7:0] ctrlByte;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic flagClr;
  logic ownHit;
  logic gcHit;

  tws_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn({sclIn, sdaIn}),
    .pinOut(pins)
  );

  tws_wb_port u_wb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .rdWord(rdWord),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .wrEn(wrEn)
  );

  assign scl = pins[1];
  assign sda = pins[0];
  assign lowLane = wb_sel_i[0];
  assign ctrlByte = {r.flag, r.ackEn, r.startReq, r.stopReq, r.wcol,
                     r.ifEn, 1'b0, r.irqEn};
  assign sclRise = scl && !r.sclPrev;
  assign sclFall = !scl && r.sclPrev;
  assign startCond = scl && r.sclPrev && r.sdaPrev && !sda;
  assign stopCond = scl && r.sclPrev && !r.sdaPrev && sda;
  // Address compare on the received byte
  assign ownHit = r.shift[7:1] == r.osa[7:1];
  assign gcHit = (r.shift == tws_pkg::GC_ADDR) && r.osa[tws_pkg::OSA_GC_EN];

  // Register read mux
  always_comb begin
    rdWord = '0;
    if (wb_adr_i == tws_pkg::OFS_OWN_ADDR) begin
      rdWord[7:0] = r.osa;
    end else if (wb_adr_i == tws_pkg::OFS_CONTROL) begin
      rdWord[7:0] = ctrlByte;
    end else if (wb_adr_i == tws_pkg::OFS_STATUS) begin
      rdWord[7:0] = r.status;
    end else if (wb_adr_i == tws_pkg::OFS_DATA) begin
      rdWord[7:0] = r.dataReg;
    end
  end

  always_comb begin
    next_r = r;
    flagClr = 1'b0;
    next_r.sclPrev = scl;
    next_r.sdaPrev = sda;
    next_r.stSel = 1'b0;
    if (startCond) begin
      next_r.busFree = 1'b0;
    end else if (stopCond) begin
      next_r.busFree = 1'b1;
    end
    // Register writes
    if (wrEn && lowLane) begin
      if (wb_adr_i == tws_pkg::OFS_OWN_ADDR) begin
        next_r.osa = wb_dat_i[7:0];
      end else if (wb_adr_i == tws_pkg::OFS_CONTROL) begin
        flagClr = wb_dat_i[tws_pkg::CTL_FLAG];
        next_r.ackEn = wb_dat_i[tws_pkg::CTL_ACK_EN];
        next_r.startReq = wb_dat_i[tws_pkg::CTL_START];
        next_r.stopReq = wb_dat_i[tws_pkg::CTL_STOP];
        next_r.wcol = wb_dat_i[tws_pkg::CTL_WCOL];
        next_r.ifEn = wb_dat_i[tws_pkg::CTL_IF_EN];
        next_r.irqEn = wb_dat_i[tws_pkg::CTL_IRQ_EN];
      end else if (wb_adr_i == tws_pkg::OFS_DATA) begin
        next_r.wcol = r.wcol || !r.flag;
      end
    end
    if (flagClr) begin
      next_r.flag = 1'b0;
      next_r.wake = 1'b0;
    end
    if (r.startReq && r.busFree && r.state == tws_pkg::ST_IDLE) begin
      next_r.startReq = 1'b0;
    end
    // Bus state machine; a set of the flag below wins over the clear
    if (!r.ifEn) begin
      next_r.state = tws_pkg::ST_IDLE;
      next_r.sdaDrv = 1'b0;
    end else if (startCond) begin
      next_r.state = tws_pkg::ST_ADDR;
      next_r.bitCnt = '0;
      next_r.sdaDrv = 1'b0;
    end else if (stopCond && r.state != tws_pkg::ST_HOLD) begin
      next_r.state = tws_pkg::ST_IDLE;
      next_r.sdaDrv = 1'b0;
    end else begin
      case (r.state)
        tws_pkg::ST_ADDR, tws_pkg::ST_DATA: begin
          if (sclRise) begin
            next_r.shift = {r.shift[6:0], sda};
            next_r.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == tws_pkg::BITS_PER_BYTE) begin
            if (r.state == tws_pkg::ST_DATA) begin
              next_r.ackBit = r.ackEn;
              next_r.sdaDrv = r.ackEn;
              if (!sleepMode) begin
                next_r.dataReg = r.shift;
              end
              next_r.state = tws_pkg::ST_DACK;
            end else if (r.ackEn && ownHit && r.shift[0]) begin
              next_r.stSel = 1'b1;
              next_r.state = tws_pkg::ST_IDLE;
            end else if (r.ackEn && ((ownHit && !r.shift[0]) || gcHit)) begin
              next_r.isGc = gcHit && !(ownHit && !r.shift[0]);
              next_r.sdaDrv = 1'b1;
              next_r.state = tws_pkg::ST_AACK;
            end else begin
              next_r.state = tws_pkg::ST_IDLE;
            end
          end
        end
        tws_pkg::ST_AACK: begin
          if (sclFall) begin
            next_r.sdaDrv = 1'b0;
            next_r.flag = 1'b1;
            next_r.nackd = 1'b0;
            next_r.wake = sleepMode;
            next_r.state = tws_pkg::ST_HOLD;
            if (r.isGc) begin
              next_r.status = arbLost ? tws_pkg::SC_ARB_GC : tws_pkg::SC_GC;
            end else begin
              next_r.status = arbLost ? tws_pkg::SC_ARB_OWN_W
                                      : tws_pkg::SC_OWN_W;
            end
          end
        end
        tws_pkg::ST_DACK: begin
          if (sclFall) begin
            next_r.sdaDrv = 1'b0;
            next_r.flag = 1'b1;
            next_r.nackd = !r.ackBit;
            next_r.state = tws_pkg::ST_HOLD;
            if (r.isGc) begin
              next_r.status = r.ackBit ? tws_pkg::SC_GC_ACK
                                       : tws_pkg::SC_GC_NACK;
            end else begin
              next_r.status = r.ackBit ? tws_pkg::SC_DATA_ACK
                                       : tws_pkg::SC_DATA_NACK;
            end
          end
        end
        tws_pkg::ST_HOLD: begin
          if (flagClr) begin
            next_r.bitCnt = '0;
            next_r.state = r.nackd ? tws_pkg::ST_IDLE : tws_pkg::ST_DATA;
          end
        end
        default: begin
          next_r.sdaDrv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
      r.osa <= tws_pkg::OSA_RST;
      r.status <= tws_pkg::STATUS_RST;
      r.sclPrev <= 1'b1;
      r.sdaPrev <= 1'b1;
      r.busFree <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = r.state == tws_pkg::ST_HOLD && r.flag;
  assign sdaOe = r.sdaDrv;
  assign wakeRequest = r.wake;
  assign slaveTransmitSel = r.stSel;
  assign startPending = r.startReq && r.busFree;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_stretch;
    r.flag && r.state == tws_pkg::ST_HOLD && !flagClr |=> sclOe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("SCL not held");

  property p_own_ack;
    r.state == tws_pkg::ST_AACK && !r.isGc |-> r.shift[7:1] == r.osa[7:1];
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("Bad address ack");

  property p_gc_gate;
    r.state == tws_pkg::ST_AACK && r.isGc |-> r.osa[tws_pkg::OSA_GC_EN];
  endproperty
  a_gc_gate: assert property (p_gc_gate) else $error("General call acked");

  property p_code_own;
    r.state == tws_pkg::ST_AACK && !r.isGc && !arbLost && sclFall
      |=> r.flag && r.status == tws_pkg::SC_OWN_W;
  endproperty
  a_code_own: assert property (p_code_own) else $error("Expected 0x60");

  property p_code_gc;
    r.state == tws_pkg::ST_AACK && r.isGc && !arbLost && sclFall
      |=> r.status == tws_pkg::SC_GC;
  endproperty
  a_code_gc: assert property (p_code_gc) else $error("Expected 0x70");

  property p_nack;
    r.state == tws_pkg::ST_DACK && !r.ackBit |-> !sdaOe;
  endproperty
  a_nack: assert property (p_nack) else $error("Data acked");

  property p_data;
    $rose(r.flag) && r.status == tws_pkg::SC_DATA_ACK
      |-> r.dataReg == $past(r.shift, 2) || sleepMode;
  endproperty
  a_data: assert property (p_data) else $error("Data not captured");

  property p_disabled;
    !r.ifEn |=> (!sdaOe && !sclOe) [*2];
  endproperty
  a_disabled: assert property (p_disabled) else $error("Drives bus off");

  property p_release;
    r.state == tws_pkg::ST_HOLD && flagClr |=> !r.flag ##1 !sclOe;
  endproperty
  a_release: assert property (p_release) else $error("Flag not cleared");

  property p_wake;
    wakeRequest |-> sclOe;
  endproperty
  a_wake: assert property (p_wake) else $error("Wake without hold");
endmodule // tws_slave_rx

// [sim/tws_master_model.sv]
// Behavioural two-wire bus master transmitter
module tws_master_model (
  input wire logic sclW,
  input wire logic sdaW,
  output logic sclLow,
  output logic sdaLow,
  output logic hang
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    hang = 1'b0;
  end
  // Release SCL, bounded wait on stretching
  task automatic sclHigh();
    int n;
    n = 0;
    sclLow = 1'b0;
    while (sclW !== 1'b1 && n < 4000) begin
      #5;
      n++;
    end
    if (n >= 4000) hang = 1'b1;
  endtask
  task automatic start();
    sdaLow = 1'b0;
    sclHigh();
    #20 sdaLow = 1'b1;
    #20 sclLow = 1'b1;
  endtask
  task automatic stop();
    #20 sdaLow = 1'b1;
    #20 sclHigh();
    #20 sdaLow = 1'b0;
    #40;
  endtask
  // MSB first, ninth clock samples ack
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #20 sdaLow = (i >= 0) ? !b[i] : 1'b0;
      #20 sclHigh();
      #20 if (i < 0) ack = !sdaW;
      #20 sclLow = 1'b1;
    end
  endtask
endmodule // tws_master_model

// [sim/tws_slave_rx_tb.sv]
// Self-checking bench of the two-wire slave receiver
module tws_slave_rx_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, cyc, stb, we, sleepMode, arbLost, a, txSeen;
  logic [3:0] adr;
  logic [31:0] wdat, rdat;
  logic ack, sclOe, sdaOe, wake, txSel, sclLow, sdaLow, hang;
  logic startPend, pendSeen;
  logic [3:0] sel, selNext;
  logic [7:0] osa, q;
  logic [31:0] rng;
  int failures, checked, mEn, mAck;
  wire logic sclW;
  wire logic sdaW;
  assign sclW = !(sclOe | sclLow);
  assign sdaW = !(sdaOe | sdaLow);
  tws_slave_rx u_tws_slave_rx (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sclIn(sclW), .sclOut(),
    .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(), .sdaOe(sdaOe),
    .sleepMode(sleepMode), .arbLost(arbLost), .wakeRequest(wake),
    .slaveTransmitSel(txSel), .startPending(startPend)
  );
  tws_master_model u_tws_master_model (
    .sclW(sclW), .sdaW(sdaW), .sclLow(sclLow), .sdaLow(sdaLow),
    .hang(hang)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (txSel === 1'b1) txSeen <= 1'b1;
    if (startPend === 1'b1) pendSeen <= 1'b1;
  end
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Classic single cycle, bounded wait on ack
  task automatic wb(input logic w, input logic [3:0] ad,
                    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= selNext;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      test_done();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic ctlw(input logic [7:0] c);
    wb(1'b1, tws_pkg::OFS_CONTROL, c);
    mAck = c[tws_pkg::CTL_ACK_EN];
    mEn = c[tws_pkg::CTL_IF_EN];
  endtask
  task automatic addrPh(input logic [7:0] b);
    logic e;
    logic [7:0] st;
    e = mEn && mAck && ((b[7:1] == osa[7:1] && !b[0])
        || (b == 8'h00 && osa[0]));
    st = (b == 8'h00 ? 8'h70 : 8'h60) + (arbLost ? 8'h08 : 8'h00);
    u_tws_master_model.start();
    u_tws_master_model.sendByte(b, a);
    chk(a, e);
    if (e) begin
      repeat (8) @(posedge clk_sys);
      wb(1'b0, tws_pkg::OFS_STATUS, 8'h00);
      chk(q, st);
      wb(1'b0, tws_pkg::OFS_CONTROL, 8'h00);
      chk(q[7], 1'b1);
      chk(sclOe, 1'b1);
    end
  endtask
  task automatic datPh();
    logic [7:0] b;
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    b = rng[7:0];
    u_tws_master_model.sendByte(b, a);
    chk(a, mAck[0]);
    repeat (8) @(posedge clk_sys);
    wb(1'b0, tws_pkg::OFS_STATUS, 8'h00);
    chk(q, mAck ? 8'h80 : 8'h88);
    wb(1'b0, tws_pkg::OFS_DATA, 8'h00);
    chk(q, b);
  endtask
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, sleepMode, arbLost, txSeen, pendSeen} = 7'h00;
    sel = 4'h0;
    selNext = 4'hF;
    adr = 4'h0;
    wdat = 32'h0;
    rng = 32'h13E7;
    {mEn, mAck} = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wb(1'b0, tws_pkg::OFS_OWN_ADDR, 8'h00);
    chk(q, 8'hFE);
    wb(1'b0, tws_pkg::OFS_STATUS, 8'h00);
    chk(q, 8'hF8);
    wb(1'b0, tws_pkg::OFS_CONTROL, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, 4'h2, 8'h00);
    chk(q, 8'h00);
    selNext = 4'hE;
    wb(1'b1, tws_pkg::OFS_OWN_ADDR, 8'h12);
    selNext = 4'hF;
    wb(1'b1, tws_pkg::OFS_DATA, 8'h55);
    wb(1'b0, tws_pkg::OFS_OWN_ADDR, 8'h00);
    chk(q, 8'hFE);
    wb(1'b0, tws_pkg::OFS_CONTROL, 8'h00);
    chk(q, 8'h08);
    osa = 8'hA0;
    wb(1'b1, tws_pkg::OFS_OWN_ADDR, osa);
    ctlw(8'h40);
    addrPh(8'hA0);
    u_tws_master_model.stop();
    ctlw(8'h44);
    addrPh(8'hA2);
    u_tws_master_model.stop();
    addrPh(8'h00);
    u_tws_master_model.stop();
    addrPh(8'hA0);
    ctlw(8'hC4);
    datPh();
    ctlw(8'hC4);
    datPh();
    ctlw(8'h84);
    datPh();
    ctlw(8'h84);
    u_tws_master_model.stop();
    addrPh(8'hA0);
    u_tws_master_model.stop();
    ctlw(8'h44);
    addrPh(8'hA0);
    ctlw(8'hC4);
    u_tws_master_model.stop();
    osa = 8'hA1;
    wb(1'b1, tws_pkg::OFS_OWN_ADDR, osa);
    addrPh(8'hA1);
    chk(txSeen, 1'b1);
    u_tws_master_model.stop();
    addrPh(8'h00);
    ctlw(8'hC4);
    arbLost <= 1'b1;
    u_tws_master_model.stop();
    addrPh(8'h00);
    ctlw(8'hC4);
    u_tws_master_model.stop();
    addrPh(8'hA0);
    ctlw(8'hC4);
    arbLost <= 1'b0;
    sleepMode <= 1'b1;
    u_tws_master_model.stop();
    addrPh(8'hA0);
    chk(wake, 1'b1);
    ctlw(8'hE4);
    @(posedge clk_sys);
    chk(wake, 1'b0);
    chk(startPend, 1'b0);
    sleepMode <= 1'b0;
    u_tws_master_model.stop();
    repeat (8) @(posedge clk_sys);
    chk(pendSeen, 1'b1);
    chk(hang, 1'b0);
    test_done();
  end
endmodule // tws_slave_rx_tb
